// ===== shared_irq_pin.sv
// shared open-drain interrupt / test / level pin controller with apb registers
// Overview of operation
// RQ1: timer, osc-fail, alarm 1 and watchdog requests are ORed into one request.
// RQ2: frequency-test enable, when selected, puts the 512 Hz square wave on the pin.
// RQ3: backup mode masks timer and watchdog; alarm 1 and osc-fail stay active.
// RQ4: main supply, level bit 0, test off: pin low whatever the interrupts.
// RQ5: main supply, test on: square wave if level bit 0 or no enable.
// RQ6: main supply, level 1, some enable: pin high until an enabled source fires.
// RQ7: main supply, level 1, test off, no enables: pin high.
// RQ8: level bit is calibration bit 7, test enable bit 6, index 08h.
// RQ9: backup enable bit 5 and alarm 1 enable bit 7 at index 0Ah.
// RQ10: osc-fail enable is bit 7 of 09h, timer enable bit 5 of 11h.
// RQ11: backup mode never outputs the test wave; test enable ignored there. Shared pin only; test_reset_pin follows sq_512 if the enable is set again.
// RQ12: backup with backup enable 0: pin high regardless of everything.
// RQ13: backup, level 1, no alarm 1 or osc-fail enable: pin high.
// RQ14: backup, backup enable 1, level 0: pin low regardless of sources.
// RQ15: backup interrupts need level 1, backup enable 1 and an applicable enable.
// RQ16: pin is open drain: only pulled low or released to the pull-up.
// RQ17: host reads flags at 0Fh to find every source holding the pin.
// RQ18: extra sources while low cause no transition; low until all cleared.
// RQ19: host services every pending source before the pin can release.
// RQ20: test/reset pin: wave when test enable 1, high when 0 on main supply.
// RQ21: supply failing with test enabled clears the enable and drives reset low.
// RQ22: after reset the test enable is 0, so test/reset pin acts as reset.
// RQ23: osc-fail flag stays set until written 0; reading does not clear it.
// RQ24: clearing osc-fail enable releases pin; re-setting with flag set reasserts.
// RQ25: priority table follows the power-mode indication as soon as it changes. Here on_backup first passes the three-stage synchroniser and glitch filter.
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module shared_irq_pin
    import shared_irq_pkg::*;
#(
    parameter int ADDR_W = shared_irq_pkg::APB_ADDR_W
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [shared_irq_pkg::APB_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [shared_irq_pkg::APB_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer_event,
    input wire logic alarm1_event,
    input wire logic watchdog_event,
    input wire logic osc_fail_event,
    input wire logic on_backup,
    input wire logic clk_512,
    input wire logic shared_irq_pin_in,
    output logic shared_irq_pin_out,
    output logic shared_irq_pin_oe_n,
    output logic test_reset_pin
);
    import shared_irq_pkg::*;

    logic [2:0] async_in;
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] sync_c;
    logic [2:0] filt;
    logic backup;
    logic backup_d;
    logic fail_edge;
    logic sq_512;
    logic pin_level;
    logic [REG_W-1:0] calib;
    logic [REG_W-1:0] wdog;
    logic [REG_W-1:0] alarm1_month;
    logic [REG_W-1:0] timer_ctrl;
    logic wdog_flag;
    logic alarm1_flag;
    logic timer_flag;
    logic osc_fail_flag;
    logic complete;
    logic wr_en;
    logic wr_calib;
    logic wr_wdog;
    logic wr_alarm1;
    logic wr_flags;
    logic wr_timer;
    logic [APB_DATA_W-1:0] read_value;
    logic out_level;
    logic freq_test_enable;
    logic alarm1_irq_enable;
    logic backup_irq_enable;
    logic osc_fail_irq_enable;
    logic timer_irq_enable;
    logic wdog_running;
    logic any_en_main;
    logic any_en_backup;
    logic irq_req;
    logic next_pin_release;
    logic next_test_reset;

    // true when the address is word aligned and selects the given register index
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [IDX_W-1:0] idx);
        return (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == (ADDR_W-2)'(idx));
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] addr);
        return reg_hit(addr, IDX_CALIB) || reg_hit(addr, IDX_WDOG) ||
            reg_hit(addr, IDX_ALARM1_MONTH) || reg_hit(addr, IDX_FLAGS) ||
            reg_hit(addr, IDX_TIMER_CTRL);
    endfunction

    // hardware set wins over a clear arriving in the same cycle
    function automatic logic sticky(input logic flag, input logic set, input logic clr);
        return set | (flag & ~clr);
    endfunction

    // power mode, test wave and pin readback come from outside the clock domain
    assign async_in = {shared_irq_pin_in, clk_512, on_backup};

    // three-stage synchroniser; the first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_a <= RST_SYNC;
            sync_b <= RST_SYNC;
            sync_c <= RST_SYNC;
        end
        else
        begin
            sync_a <= async_in;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // a lane changes only once stages two and three agree, which rejects one-cycle glitches
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            filt <= RST_SYNC;
        else
            filt <= (sync_b & sync_c) | (filt & (sync_b ^ sync_c));
    end

    assign backup = filt[LANE_BACKUP];
    assign sq_512 = filt[LANE_SQ512];
    assign pin_level = filt[LANE_PIN];

    // previous power mode, for the supply-fail edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            backup_d <= 1'b0;
        else
            backup_d <= backup;
    end

    assign fail_edge = backup && !backup_d;

    // apb decode: a write lands only at the edge where pready is sampled high
    assign complete = psel && penable && pready;
    assign wr_en = complete && pwrite && pstrb[0];
    assign wr_calib = wr_en && reg_hit(paddr, IDX_CALIB);
    assign wr_wdog = wr_en && reg_hit(paddr, IDX_WDOG);
    assign wr_alarm1 = wr_en && reg_hit(paddr, IDX_ALARM1_MONTH);
    assign wr_flags = wr_en && reg_hit(paddr, IDX_FLAGS);
    assign wr_timer = wr_en && reg_hit(paddr, IDX_TIMER_CTRL);

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else
            pready <= psel && penable && !pready;
    end

    // read data and error are captured together with pready
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
            pslverr <= 1'b0;
        end
        else if (psel && penable && !pready)
        begin
            prdata <= pwrite ? '0 : read_value;
            pslverr <= !mapped(paddr);
        end
        else
            pslverr <= 1'b0;
    end

    // read multiplexer; reading the flags register has no side effect
    always_comb
    begin
        read_value = '0;
        if (reg_hit(paddr, IDX_CALIB))
            read_value[REG_W-1:0] = calib;
        else if (reg_hit(paddr, IDX_WDOG))
            read_value[REG_W-1:0] = wdog;
        else if (reg_hit(paddr, IDX_ALARM1_MONTH))
            read_value[REG_W-1:0] = alarm1_month;
        else if (reg_hit(paddr, IDX_TIMER_CTRL))
            read_value[REG_W-1:0] = timer_ctrl;
        else if (reg_hit(paddr, IDX_FLAGS))
        begin
            read_value[BIT_WDOG_FLAG] = wdog_flag; // see RQ17
            read_value[BIT_ALARM1_FLAG] = alarm1_flag;
            read_value[BIT_TIMER_FLAG] = timer_flag;
            read_value[BIT_OSC_FAIL_FLAG] = osc_fail_flag; // see RQ23
            read_value[BIT_PIN_LEVEL] = pin_level;
        end
    end

    // calibration register; a supply failure clears the test enable over any write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            calib <= RST_CALIB; // see RQ22
        else
        begin
            if (wr_calib)
                calib <= pwdata[REG_W-1:0]; // see RQ8
            if (fail_edge)
                calib[BIT_FREQ_TEST] <= 1'b0; // see RQ21
        end
    end

    // enable registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wdog <= RST_WDOG;
            alarm1_month <= RST_ALARM1_MONTH;
            timer_ctrl <= RST_TIMER_CTRL;
        end
        else
        begin
            if (wr_wdog)
                wdog <= pwdata[REG_W-1:0]; // see RQ10
            if (wr_alarm1)
                alarm1_month <= pwdata[REG_W-1:0]; // see RQ9
            if (wr_timer)
                timer_ctrl <= pwdata[REG_W-1:0]; // see RQ10
        end
    end

    // sticky source flags: writing 0 clears, writing 1 leaves the flag alone
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wdog_flag <= RST_EVENT_FLAG;
            alarm1_flag <= RST_EVENT_FLAG;
            timer_flag <= RST_EVENT_FLAG;
            osc_fail_flag <= RST_OSC_FAIL_FLAG;
        end
        else
        begin
            // re-arming the watchdog also services its flag
            wdog_flag <= sticky(wdog_flag, watchdog_event,
                wr_wdog || (wr_flags && !pwdata[BIT_WDOG_FLAG])); // see RQ19
            alarm1_flag <= sticky(alarm1_flag, alarm1_event,
                wr_flags && !pwdata[BIT_ALARM1_FLAG]);
            timer_flag <= sticky(timer_flag, timer_event,
                wr_flags && !pwdata[BIT_TIMER_FLAG]);
            osc_fail_flag <= sticky(osc_fail_flag, osc_fail_event,
                wr_flags && !pwdata[BIT_OSC_FAIL_FLAG]); // see RQ23
        end
    end

    // enable fields
    assign out_level = calib[BIT_OUT_LEVEL];
    assign freq_test_enable = calib[BIT_FREQ_TEST];
    assign osc_fail_irq_enable = wdog[BIT_OSC_FAIL_IE];
    assign wdog_running = |wdog[WDOG_LOAD_MSB:0];
    assign alarm1_irq_enable = alarm1_month[BIT_ALARM1_IE];
    assign backup_irq_enable = alarm1_month[BIT_BACKUP_IE];
    assign timer_irq_enable = timer_ctrl[BIT_TIMER_IE];
    assign any_en_main = alarm1_irq_enable || osc_fail_irq_enable ||
        timer_irq_enable || wdog_running;
    assign any_en_backup = alarm1_irq_enable || osc_fail_irq_enable;

    // combined request; the pin stays low until every enabled source is serviced, except timer and watchdog in backup
    assign irq_req = (alarm1_irq_enable && alarm1_flag) ||
        (osc_fail_irq_enable && osc_fail_flag) || // see RQ24
        (!backup && ((timer_irq_enable && timer_flag) || // see RQ3
        (wdog_running && wdog_flag))); // see RQ1, see RQ18

    // pin priority, chosen from the filtered power mode in the same cycle it changes
    always_comb
    begin
        next_pin_release = 1'b1;
        if (!backup) // see RQ25
        begin
            if (!out_level)
                next_pin_release = freq_test_enable ? sq_512 : 1'b0; // see RQ4, see RQ5
            else if (any_en_main)
                next_pin_release = !irq_req; // see RQ6
            else
                next_pin_release = freq_test_enable ? sq_512 : 1'b1; // see RQ2, see RQ7
        end
        else
        begin
            // the test wave never reaches the pin in backup
            if (!backup_irq_enable)
                next_pin_release = 1'b1; // see RQ12, see RQ11
            else if (!out_level)
                next_pin_release = 1'b0; // see RQ14
            else if (!any_en_backup)
                next_pin_release = 1'b1; // see RQ13
            else
                next_pin_release = !irq_req; // see RQ15
        end
    end

    // combined test/reset output: low in backup once the enable has been dropped
    assign next_test_reset = freq_test_enable ? sq_512 : !backup; // see RQ20

    // open-drain driver: data is always 0, only the enable moves
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shared_irq_pin_out <= 1'b0;
            shared_irq_pin_oe_n <= 1'b1;
            test_reset_pin <= 1'b0;
        end
        else
        begin
            shared_irq_pin_out <= 1'b0; // see RQ16
            shared_irq_pin_oe_n <= next_pin_release;
            test_reset_pin <= next_test_reset; // see RQ21
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_out_dominates: assert property (!backup && !out_level && !freq_test_enable |=> !shared_irq_pin_oe_n) // see RQ4
        else $error("level bit 0 did not hold the pin low");
    a_test_wave_main: assert property (!backup && freq_test_enable && (!out_level || !any_en_main)
        |=> shared_irq_pin_oe_n == $past(sq_512)) // see RQ5
        else $error("test wave missing on the shared pin");
    a_irq_pulls_low: assert property (!backup && out_level && any_en_main && irq_req
        |=> !shared_irq_pin_oe_n) // see RQ6
        else $error("enabled source did not pull the pin low");
    a_main_idle_high: assert property (!backup && out_level && !freq_test_enable && !any_en_main
        |=> shared_irq_pin_oe_n) // see RQ7
        else $error("idle pin not released on main supply");
    a_backup_abe_off: assert property (backup && !backup_irq_enable |=> shared_irq_pin_oe_n) // see RQ12
        else $error("pin driven in backup without backup enable");
    a_backup_out_low: assert property (backup && backup_irq_enable && !out_level
        |=> !shared_irq_pin_oe_n) // see RQ14
        else $error("level bit 0 did not pull pin low in backup");
    a_backup_masks: assert property (backup && !(alarm1_irq_enable && alarm1_flag)
        && !(osc_fail_irq_enable && osc_fail_flag) |-> !irq_req) // see RQ3
        else $error("timer or watchdog reached the request in backup");
    a_backup_no_wave: assert property (backup && backup_irq_enable && out_level && !irq_req
        |=> shared_irq_pin_oe_n) // see RQ11
        else $error("pin not high in backup with no request");
    a_osc_flag_sticky: assert property (osc_fail_flag && !(wr_flags && !pwdata[BIT_OSC_FAIL_FLAG])
        |=> osc_fail_flag) // see RQ23
        else $error("osc-fail flag cleared without a write of 0");
    a_fail_clears_ft: assert property (fail_edge && freq_test_enable
        |=> !freq_test_enable ##1 !test_reset_pin) // see RQ21
        else $error("supply failure did not clear test enable and assert reset");
    a_apb_one_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("apb answer not one wait state after access");
    a_pin_data_zero: assert property (!shared_irq_pin_out) // see RQ16
        else $error("open-drain data driven high");

    c_irq_main: cover property (!backup && out_level && irq_req ##1 !shared_irq_pin_oe_n);
    c_irq_backup: cover property (backup && backup_irq_enable && out_level && irq_req
        ##1 !shared_irq_pin_oe_n);
    c_wave_toggle: cover property (freq_test_enable && !backup ##1 $rose(shared_irq_pin_oe_n));
    c_fail_reset: cover property (fail_edge && freq_test_enable ##2 !test_reset_pin);
endmodule // shared_irq_pin
`default_nettype wire

// ===== shared_irq_pkg.sv
// shared interrupt pin controller: register map, field positions and reset values
package shared_irq_pkg;
    // bus widths
    localparam int APB_ADDR_W = 8;
    localparam int APB_DATA_W = 32;
    localparam int REG_W = 8;
    localparam int IDX_W = 6;
    // register indices; byte address on the bus is four times the index
    localparam logic [5:0] IDX_CALIB = 6'h08;
    localparam logic [5:0] IDX_WDOG = 6'h09;
    localparam logic [5:0] IDX_ALARM1_MONTH = 6'h0A;
    localparam logic [5:0] IDX_FLAGS = 6'h0F;
    localparam logic [5:0] IDX_TIMER_CTRL = 6'h11;
    // digital calibration fields
    localparam int BIT_OUT_LEVEL = 7;
    localparam int BIT_FREQ_TEST = 6;
    // watchdog fields
    localparam int BIT_OSC_FAIL_IE = 7;
    localparam int WDOG_LOAD_MSB = 6;
    // alarm 1 month fields
    localparam int BIT_ALARM1_IE = 7;
    localparam int BIT_BACKUP_IE = 5;
    // timer control fields
    localparam int BIT_TIMER_IE = 5;
    // flags register fields
    localparam int BIT_WDOG_FLAG = 7;
    localparam int BIT_ALARM1_FLAG = 6;
    localparam int BIT_TIMER_FLAG = 3;
    localparam int BIT_OSC_FAIL_FLAG = 2;
    localparam int BIT_PIN_LEVEL = 1;
    // reset values
    localparam logic [7:0] RST_CALIB = 8'h80;
    localparam logic [7:0] RST_WDOG = 8'h00;
    localparam logic [7:0] RST_ALARM1_MONTH = 8'h00;
    localparam logic [7:0] RST_TIMER_CTRL = 8'h00;
    localparam logic RST_OSC_FAIL_FLAG = 1'b1;
    localparam logic RST_EVENT_FLAG = 1'b0;
    // synchroniser lanes: {pin level, 512 hz test clock, backup mode}
    localparam logic [2:0] RST_SYNC = 3'h4;
    localparam int LANE_BACKUP = 0;
    localparam int LANE_SQ512 = 1;
    localparam int LANE_PIN = 2;
    // frequency of the test square wave fed in on clk_512
    localparam int TEST_FREQ_HZ = 512;
endpackage

// ===== host_pullup.sv
// host side of the shared interrupt wire: pull-up and the level the host sees
`timescale 1ns/1ns
`default_nettype none
module host_pullup
(
    input wire logic pin_out,
    input wire logic pin_oe_n,
    output logic wire_level,
    output logic irq_seen_n
);
    // a released wire floats to the pull-up, so no stale level is ever shown
    assign wire_level = pin_oe_n ? 1'b1 : pin_out;
    // the host only ever sees the resolved wire, never the device's data bit
    assign irq_seen_n = wire_level;
endmodule // host_pullup
`default_nettype wire

// ===== shared_irq_pin_priority_tb.sv
// self-checking bench for the shared interrupt pin controller
`timescale 1ns/1ns
`default_nettype none
module shared_irq_pin_priority_tb;
    import shared_irq_pkg::*;
    localparam logic [7:0] A_CAL = {IDX_CALIB, 2'b00};
    localparam logic [7:0] A_WD = {IDX_WDOG, 2'b00};
    localparam logic [7:0] A_AL = {IDX_ALARM1_MONTH, 2'b00};
    localparam logic [7:0] A_FL = {IDX_FLAGS, 2'b00};
    localparam logic [7:0] A_TM = {IDX_TIMER_CTRL, 2'b00};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic timer_event, alarm1_event, watchdog_event, osc_fail_event, on_backup, clk_512;
    logic pin_out, pin_oe_n, pin_wire, irq_n, test_reset_pin;
    int bad_count, n_tests, cycles;

    shared_irq_pin dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_event(timer_event),
        .alarm1_event(alarm1_event), .watchdog_event(watchdog_event),
        .osc_fail_event(osc_fail_event), .on_backup(on_backup), .clk_512(clk_512),
        .shared_irq_pin_in(pin_wire), .shared_irq_pin_out(pin_out),
        .shared_irq_pin_oe_n(pin_oe_n), .test_reset_pin(test_reset_pin));
    host_pullup host (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .wire_level(pin_wire),
        .irq_seen_n(irq_n));

    // free-running bus clock, 4 ns period
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // hang guard: far above the several hundred cycles the scenarios need
    always @(posedge pclk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            $display("CHECK FAILED %0t cycle limit reached", $time);
            bad_count = bad_count + 1;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp, input string m);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %0t %s got %b exp %b", $time, m, got, exp);
        end
    endtask

    // one apb transfer; pready, prdata and pslverr are read just after a rising edge,
    // before the slave's own update lands, so they are the values sampled at that edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge pclk);
            n++;
        end
        if (pready !== 1'b1)
        begin
            bad_count++;
            $display("CHECK FAILED %0t apb transfer got no answer", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cfg(input logic [7:0] cal, input logic [7:0] al, input logic [7:0] wd,
        input logic [7:0] tm);
        apb(1'b1, A_CAL, {24'h0, cal});
        apb(1'b1, A_AL, {24'h0, al});
        apb(1'b1, A_WD, {24'h0, wd});
        apb(1'b1, A_TM, {24'h0, tm});
    endtask

    // bits {timer, alarm 1, watchdog, osc-fail}, held high for one cycle
    task automatic pulse(input logic [3:0] m);
        @(posedge pclk);
        {timer_event, alarm1_event, watchdog_event, osc_fail_event} <= m;
        @(posedge pclk);
        {timer_event, alarm1_event, watchdog_event, osc_fail_event} <= 4'h0;
    endtask

    // enough edges for the input synchronisers, filter and pin register
    task automatic pin_is(input logic e, input string m);
        repeat (10) @(posedge pclk);
        @(negedge pclk);
        cmp_bit(irq_n, e, m);
    endtask

    // the test clock is stepped by hand: a true 512 Hz period is far too long
    task automatic wave_check(input logic follow, input logic lvl, input string m);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge pclk);
            clk_512 <= ~i[0];
            pin_is(follow ? ~i[0] : lvl, m);
            if (follow)
                cmp_bit(test_reset_pin, ~i[0], "test pin wave");
        end
    endtask

    task automatic t_reset();
        apb(1'b0, A_CAL, 32'h0);
        cmp_word(rd, 32'h80, "calib reset");
        apb(1'b0, A_FL, 32'h0);
        cmp_word(rd, (32'h1 << BIT_OSC_FAIL_FLAG) | (32'h1 << BIT_PIN_LEVEL), "flags");
        cmp_bit(test_reset_pin, 1'b1, "test pin idle");
        pin_is(1'b1, "idle high");
        apb(1'b0, 8'h04, 32'h0);
        cmp_bit(err, 1'b1, "unmapped");
        apb(1'b0, 8'h21, 32'h0);
        cmp_bit(err, 1'b1, "misaligned");
        apb(1'b1, A_AL, 32'hA5);
        apb(1'b0, A_AL, 32'h0);
        cmp_word(rd, 32'hA5, "readback");
        // a write without the low byte strobe must leave the register alone
        pstrb <= 4'hE;
        apb(1'b1, A_AL, 32'h00);
        pstrb <= 4'hF;
        apb(1'b0, A_AL, 32'h0);
        cmp_word(rd, 32'hA5, "strobe off ignored");
        apb(1'b1, A_FL, 32'h0);
    endtask

    task automatic t_main();
        cfg(8'h00, 8'h80, 8'h00, 8'h00);
        pulse(4'h4);
        pin_is(1'b0, "level low dominates");
        apb(1'b1, A_CAL, 32'h40);
        wave_check(1'b1, 1'b0, "wave over enable");
        cfg(8'hC0, 8'h00, 8'h00, 8'h00);
        wave_check(1'b1, 1'b0, "wave no enable");
        apb(1'b1, A_CAL, 32'h80);
        pin_is(1'b1, "level high");
        cfg(8'h80, 8'h80, 8'h01, 8'h20);
        pin_is(1'b0, "pending alarm");
        apb(1'b1, A_FL, 32'h0);
        pin_is(1'b1, "released");
        pulse(4'h4);
        pulse(4'hA);
        pin_is(1'b0, "stays low");
        apb(1'b0, A_FL, 32'h0);
        cmp_word(rd, 32'hC8, "pending set");
        apb(1'b1, A_FL, 32'h1 << BIT_WDOG_FLAG);
        pin_is(1'b0, "watchdog still pending");
        apb(1'b1, A_WD, 32'h01);
        pin_is(1'b1, "re-armed");
    endtask

    task automatic t_sources();
        cfg(8'h80, 8'h80, 8'h81, 8'h20);
        for (int k = 0; k < 4; k++)
        begin
            pulse(4'h1 << k);
            pin_is(1'b0, "one source");
            apb(1'b1, A_FL, 32'h0);
            pin_is(1'b1, "cleared");
        end
        pulse(4'h1);
        apb(1'b0, A_FL, 32'h0);
        apb(1'b0, A_FL, 32'h0);
        cmp_word(rd, 32'h1 << BIT_OSC_FAIL_FLAG, "read keeps flag");
        pin_is(1'b0, "read no release");
        apb(1'b1, A_WD, 32'h01);
        pin_is(1'b1, "enable off");
        apb(1'b1, A_WD, 32'h81);
        pin_is(1'b0, "enable on again");
        apb(1'b1, A_FL, 32'h0);
    endtask

    task automatic t_backup();
        cfg(8'hC0, 8'h80, 8'h01, 8'h20);
        @(posedge pclk);
        on_backup <= 1'b1;
        repeat (12) @(posedge pclk);
        apb(1'b0, A_CAL, 32'h0);
        cmp_word(rd, 32'h80, "test bit cleared");
        cmp_bit(test_reset_pin, 1'b0, "reset low");
        pulse(4'h4);
        pin_is(1'b1, "no backup enable");
        apb(1'b1, A_CAL, 32'h40);
        wave_check(1'b0, 1'b1, "no wave in backup");
        apb(1'b1, A_AL, 32'h20);
        pin_is(1'b0, "level low");
        apb(1'b1, A_CAL, 32'hC0);
        wave_check(1'b0, 1'b1, "no applicable enable");
        pulse(4'hA);
        pin_is(1'b1, "timer wdog masked");
        apb(1'b1, A_AL, 32'hA0);
        pin_is(1'b0, "alarm in backup");
        apb(1'b1, A_FL, 32'hBF);
        pin_is(1'b1, "only masked left");
        @(posedge pclk);
        on_backup <= 1'b0;
        pin_is(1'b0, "main table again");
        apb(1'b1, A_CAL, 32'h80);
        // the write lands at the completing edge, the pin register one edge later
        repeat (2) @(negedge pclk);
        cmp_bit(test_reset_pin, 1'b1, "supply good");
    endtask

    // main sequence: all inputs set at time zero, reset for two cycles
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {timer_event, alarm1_event, watchdog_event, osc_fail_event} = 4'h0;
        on_backup = 1'b0;
        clk_512 = 1'b0;
        pstrb = 4'hF;
        bad_count = 0;
        n_tests = 0;
        cycles = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_main();
        t_sources();
        t_backup();
        print_verdict();
    end
endmodule // shared_irq_pin_priority_tb
`default_nettype wire
